// ==== rtl/lbr_pkg.sv ====
// shared constants and carrier types for the branch recorder
// assumes a core that reports one control transfer per cycle at most
package lbr_pkg;
   // register indices as addressed by model register ops
   localparam logic [11:0] REG_SLOT_FIRST  = 12'h040;
   localparam logic [11:0] REG_SLOT_LAST   = 12'h047;
   localparam logic [11:0] REG_TOS         = 12'h1C9;
   localparam logic [11:0] REG_DBGCTL      = 12'h1D9;
   // pair organisation registers, indices chosen here
   localparam logic [11:0] REG_LB_SOURCE   = 12'h1DB;
   localparam logic [11:0] REG_LB_TARGET   = 12'h1DC;
   localparam logic [11:0] REG_LE_SOURCE   = 12'h1DD;
   localparam logic [11:0] REG_LE_TARGET   = 12'h1DE;
   // control field positions
   localparam int          CTL_REC_BIT     = 0;
   localparam int          CTL_STEP_BIT    = 1;
   localparam int          CTL_PIN_LSB     = 2;
   localparam int          CTL_MSG_BIT     = 6;
   localparam int          CTL_STORE_BIT   = 7;
   localparam int          CTL_IRQFULL_BIT = 8;
   localparam logic [8:0]  CTL_WMASK       = 9'h1FF;
   localparam logic [8:0]  CTL_RESET       = 9'h000;
   localparam logic [2:0]  TOS_RESET       = 3'h0;
   localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
   localparam int          FEAT_STORE_BIT  = 21;
   localparam int          PULSE_CYCLES    = 1;
   // transfer kinds reported by the core
   typedef enum logic [3:0]
   {
      XFER_BRANCH = 4'b0001,
      XFER_INTR   = 4'b0010,
      XFER_EXCEPT = 4'b0100,
      XFER_DEBUG  = 4'b1000
   } xfer_kind_type;
   // one control transfer event
   typedef struct packed
   {
      logic          valid;
      xfer_kind_type kind;
      logic [31:0]   source;
      logic [31:0]   target;
   } xfer_type;
   // one trace message or trace-store write
   typedef struct packed
   {
      logic        valid;
      logic        store;
      logic [31:0] source;
      logic [31:0] target;
   } trace_msg_type;
endpackage

// ==== rtl/last_branch_recorder.sv ====
// last branch / interrupt / exception recorder with debug control register
// assumes core events and register ops arrive synchronous to CORE_CLK;
// breakpoint match and perf event inputs are from the same clock domain
//
// Operation
// - control bit 0 enables recording branches, interrupts, exceptions
// - control bit 1 makes single-step flag trap only on transfers
// - each set pin-select bit routes breakpoint matches to its pin
// - breakpoint match holds the selected pin low while the match lasts, then releases it
// - clear pin-select bit reports performance events, execution unaffected
// - control bit 6 emits each branch, interrupt or exception as a trace message
// - control bit 7 logs trace messages into the store buffer
// - bit 8 set raises irq when buffer full, else circular writes
// - stack has 8 entries: source low half, target high half
// - 3-bit newest pointer readable in low bits of its register
// - pair mode: control writes only at privilege 0 or real mode
// - pair mode: debug exception clears the recording enable bit
// - pair mode: record registers undefined while messages are enabled
// - taken branch loads source with branch address, target with destination
// - interrupt or exception loads interrupted address and handler address
// - interrupt or exception first copies branch pair into exception pair
// - pair mode records code segment offsets, not linear addresses
// - pair mode: debug exception clears enable before handler, records untouched
// - debug exceptions themselves are never recorded
// - feature flag bit 21 reports debug store availability
`timescale 1ns/1ps
module last_branch_recorder
   import lbr_pkg::*;
#(
   parameter bit          STACK_ORG = 1'b1,
   parameter int          DEPTH     = 8,
   parameter int          FEAT_W    = 32
)
(
   // clock and reset
   input  wire logic                CORE_CLK,
   input  wire logic                RST_N,
   // control transfer from execution / exception logic
   input  wire xfer_type            XFER,
   input  wire logic                PRIV_OK,
   // model register read and write ops
   input  wire logic                REG_WR,
   input  wire logic                REG_RD,
   input  wire logic [11:0]         REG_ADDR,
   input  wire logic [63:0]         REG_WDATA,
   output logic      [63:0]         REG_RDATA,
   output logic                     REG_RVALID,
   output logic                     REG_WREFUSED,
   // breakpoint matches and performance events
   input  wire logic [3:0]          BP_MATCH,
   input  wire logic [3:0]          PERF_EVENT,
   output logic      [3:0]          BP_PIN_N,
   // single-step control toward the core
   input  wire logic                SINGLE_STEP_FLAG,
   output logic                     STEP_TRAP_ON_XFER,
   output logic                     STEP_TRAP_ON_INSTR,
   // trace message / store path
   output trace_msg_type            TRACE_MSG,
   input  wire logic                STORE_FULL,
   output logic                     STORE_FULL_IRQ,
   output logic                     STORE_WRAP,
   // feature identification
   output logic      [FEAT_W-1:0]   FEATURE_FLAGS
);
   localparam int PW = $clog2(DEPTH);

   // state
   logic [8:0]      ctl_ff;
   logic [PW-1:0]   tos_ff;
   logic [63:0]     stack_ff [DEPTH];
   logic [31:0]     lb_src_ff;
   logic [31:0]     lb_tgt_ff;
   logic [31:0]     le_src_ff;
   logic [31:0]     le_tgt_ff;
   logic [3:0]      pin_ff;
   logic [63:0]     rdata_ff;
   logic            rvalid_ff;
   logic            wref_ff;
   logic            step_x_ff;
   logic            step_i_ff;
   trace_msg_type   msg_ff;
   logic            irq_ff;
   logic            wrap_ff;
   logic [FEAT_W-1:0] feat_ff;

   // decoding of event kinds
   wire logic is_debug  = XFER.valid && (XFER.kind == XFER_DEBUG);
   wire logic is_intexc = XFER.valid && ((XFER.kind == XFER_INTR) || (XFER.kind == XFER_EXCEPT));
   wire logic is_branch = XFER.valid && (XFER.kind == XFER_BRANCH);
   wire logic is_rec    = is_branch || is_intexc;
   wire logic rec_on    = ctl_ff[CTL_REC_BIT];
   wire logic do_rec    = rec_on && is_rec;

   // control write acceptance; pair mode needs privilege 0 or real mode
   wire logic ctl_hit   = REG_WR && (REG_ADDR == REG_DBGCTL);
   wire logic ctl_ok    = ctl_hit && (STACK_ORG || PRIV_OK);
   wire logic [8:0] wr_ctl = REG_WDATA[8:0] & CTL_WMASK;

   // in pair mode a debug exception wins over a software write in the same cycle
   wire logic [8:0] ctl_after_wr = ctl_ok ? wr_ctl : ctl_ff;
   wire logic [8:0] nxt_ctl      = is_debug && !STACK_ORG ?
                                   (ctl_after_wr & ~(9'h001 << CTL_REC_BIT)) :
                                   ctl_after_wr;

   // pointer moves before the write so it always names the newest entry
   wire logic [PW-1:0] nxt_tos = PW'(tos_ff + 1'b1);

   // register read mux
   function automatic logic is_slot(input logic [11:0] a);
      is_slot = (a >= REG_SLOT_FIRST) && (a <= REG_SLOT_LAST);
   endfunction
   wire logic [2:0]  slot_idx = REG_ADDR[2:0];
   logic [63:0] rd_mux;
   always_comb
   begin
      rd_mux = 64'h0;
      if (STACK_ORG && is_slot(REG_ADDR))
         rd_mux = stack_ff[slot_idx];
      else if (STACK_ORG && REG_ADDR == REG_TOS)
         rd_mux = {{(64-PW){1'b0}}, tos_ff};
      else if (REG_ADDR == REG_DBGCTL)
         rd_mux = {55'h0, ctl_ff};
      else if (!STACK_ORG && REG_ADDR == REG_LB_SOURCE)
         rd_mux = {32'h0, lb_src_ff};
      else if (!STACK_ORG && REG_ADDR == REG_LB_TARGET)
         rd_mux = {32'h0, lb_tgt_ff};
      else if (!STACK_ORG && REG_ADDR == REG_LE_SOURCE)
         rd_mux = {32'h0, le_src_ff};
      else if (!STACK_ORG && REG_ADDR == REG_LE_TARGET)
         rd_mux = {32'h0, le_tgt_ff};
   end

   // breakpoint pin selection per lane; active low pin
   logic [3:0] nxt_pin;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_pin
         // pin follows the registered match level: low while the match is held, released after it drops
         assign nxt_pin[g] = ctl_ff[CTL_PIN_LSB+g] ? BP_MATCH[g]
                                                   : PERF_EVENT[g];
      end
   endgenerate

   // control register and pointer
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ctl_ff <= CTL_RESET;
         tos_ff <= '0;
      end
      else
      begin
         ctl_ff <= nxt_ctl;
         if (STACK_ORG && do_rec)
            tos_ff <= nxt_tos;
      end
   end

   // stack entries: source low, target high; no reset needed on data
   always_ff @(posedge CORE_CLK)
   begin
      if (STACK_ORG && do_rec)
         stack_ff[nxt_tos] <= {XFER.target, XFER.source};
   end

   // pair registers; source is a code segment offset from the core
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         lb_src_ff <= ADDR_RESET;
         lb_tgt_ff <= ADDR_RESET;
         le_src_ff <= ADDR_RESET;
         le_tgt_ff <= ADDR_RESET;
      end
      else if (!STACK_ORG && do_rec)
      begin
         // copy uses the old pair, nonblocking gives the ordering
         if (is_intexc)
         begin
            le_src_ff <= lb_src_ff;
            le_tgt_ff <= lb_tgt_ff;
         end
         lb_src_ff <= XFER.source;
         lb_tgt_ff <= XFER.target;
      end
   end
   // pair contents stay defined even under messages, which the
   // architecture leaves undefined

   // outputs: register answers, pins, step mode, trace path
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rdata_ff  <= 64'h0;
         rvalid_ff <= 1'b0;
         wref_ff   <= 1'b0;
         pin_ff    <= 4'hF;
         step_x_ff <= 1'b0;
         step_i_ff <= 1'b0;
         msg_ff    <= '0;
         irq_ff    <= 1'b0;
         wrap_ff   <= 1'b0;
         feat_ff   <= '0;
      end
      else
      begin
         rdata_ff  <= REG_RD ? rd_mux : 64'h0;
         rvalid_ff <= REG_RD;
         wref_ff   <= ctl_hit && !ctl_ok;
         pin_ff    <= ~nxt_pin;
         step_x_ff <= SINGLE_STEP_FLAG && ctl_ff[CTL_STEP_BIT];
         step_i_ff <= SINGLE_STEP_FLAG && !ctl_ff[CTL_STEP_BIT];
         msg_ff.valid  <= is_rec && ctl_ff[CTL_MSG_BIT];
         msg_ff.store  <= is_rec && ctl_ff[CTL_MSG_BIT] && ctl_ff[CTL_STORE_BIT];
         msg_ff.source <= XFER.source;
         msg_ff.target <= XFER.target;
         irq_ff  <= ctl_ff[CTL_STORE_BIT] && ctl_ff[CTL_IRQFULL_BIT] && STORE_FULL;
         wrap_ff <= ctl_ff[CTL_STORE_BIT] && !ctl_ff[CTL_IRQFULL_BIT];
         feat_ff <= FEAT_W'(1) << FEAT_STORE_BIT;
      end
   end

   assign REG_RDATA          = rdata_ff;
   assign REG_RVALID         = rvalid_ff;
   assign REG_WREFUSED       = wref_ff;
   assign BP_PIN_N           = pin_ff;
   assign STEP_TRAP_ON_XFER  = step_x_ff;
   assign STEP_TRAP_ON_INSTR = step_i_ff;
   assign TRACE_MSG          = msg_ff;
   assign STORE_FULL_IRQ     = irq_ff;
   assign STORE_WRAP         = wrap_ff;
   assign FEATURE_FLAGS      = feat_ff;
endmodule

// ==== testbench/lbr_props.sv ====
// port assertions for the branch recorder
// assumes one clock domain; bound into every recorder instance
`timescale 1ns/1ps
module lbr_props
   import lbr_pkg::*;
#(
   parameter bit STACK_ORG = 1'b1,
   parameter int FEAT_W    = 32
)
(
   // clock, reset and inputs
   input wire logic                CORE_CLK,
   input wire logic                RST_N,
   input wire xfer_type            XFER,
   input wire logic                PRIV_OK,
   input wire logic                REG_WR,
   input wire logic                REG_RD,
   input wire logic [11:0]         REG_ADDR,
   input wire logic [3:0]          BP_MATCH,
   input wire logic [3:0]          PERF_EVENT,
   input wire logic                SINGLE_STEP_FLAG,
   input wire logic                STORE_FULL,
   // outputs under watch
   input wire logic                REG_RVALID,
   input wire logic                REG_WREFUSED,
   input wire logic [3:0]          BP_PIN_N,
   input wire logic                STEP_TRAP_ON_XFER,
   input wire logic                STEP_TRAP_ON_INSTR,
   input wire trace_msg_type       TRACE_MSG,
   input wire logic                STORE_FULL_IRQ,
   input wire logic [FEAT_W-1:0]   FEATURE_FLAGS
);
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   // no pin event in this cycle
   sequence s_pin_quiet;
      BP_MATCH == 4'h0 && PERF_EVENT == 4'h0;
   endsequence
   // control write from an unprivileged core in pair mode
   sequence s_bad_write;
      REG_WR && REG_ADDR == REG_DBGCTL && !PRIV_OK && !STACK_ORG;
   endsequence
   a_read_answer: assert property (1'b1 |=> REG_RVALID == $past(REG_RD))
      else $error("read answer not one cycle after request");
   a_write_refused: assert property (s_bad_write |=> REG_WREFUSED)
      else $error("unprivileged write not refused");
   a_refuse_cause: assert property (REG_WREFUSED |-> !STACK_ORG && $past(REG_WR && !PRIV_OK))
      else $error("refusal without cause");
   a_msg_payload: assert property (TRACE_MSG.valid |-> $past(XFER.valid && XFER.kind != XFER_DEBUG)
      && TRACE_MSG.source == $past(XFER.source) && TRACE_MSG.target == $past(XFER.target))
      else $error("trace message without matching transfer");
   a_pin_cause: assert property (BP_PIN_N != 4'hF |-> (~BP_PIN_N & ~$past(BP_MATCH | PERF_EVENT)) == 4'h0)
      else $error("pin low without event");
   a_pin_release: assert property (s_pin_quiet |=> BP_PIN_N == 4'hF)
      else $error("pin not released");
   a_step_gate: assert property (1'b1 |=> !(STEP_TRAP_ON_XFER && STEP_TRAP_ON_INSTR)
      && (STEP_TRAP_ON_XFER || STEP_TRAP_ON_INSTR) == $past(SINGLE_STEP_FLAG))
      else $error("step trap outputs wrong");
   a_irq_full: assert property (STORE_FULL_IRQ |-> $past(STORE_FULL))
      else $error("irq without full buffer");
   a_feature_flag: assert property (1'b1 |=> FEATURE_FLAGS[FEAT_STORE_BIT] == 1'b1)
      else $error("debug store flag missing");
endmodule
bind last_branch_recorder lbr_props #(.STACK_ORG(STACK_ORG), .FEAT_W(FEAT_W)) lbr_props_inst (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .XFER(XFER), .PRIV_OK(PRIV_OK), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .BP_MATCH(BP_MATCH), .PERF_EVENT(PERF_EVENT),
   .SINGLE_STEP_FLAG(SINGLE_STEP_FLAG), .STORE_FULL(STORE_FULL), .REG_RVALID(REG_RVALID),
   .REG_WREFUSED(REG_WREFUSED), .BP_PIN_N(BP_PIN_N), .STEP_TRAP_ON_XFER(STEP_TRAP_ON_XFER),
   .STEP_TRAP_ON_INSTR(STEP_TRAP_ON_INSTR), .TRACE_MSG(TRACE_MSG), .STORE_FULL_IRQ(STORE_FULL_IRQ),
   .FEATURE_FLAGS(FEATURE_FLAGS));

// ==== testbench/core_model.sv ====
// stand-in for the core execution and exception logic
// assumes the bench asks for one transfer at a time
`timescale 1ns/1ps
module core_model
   import lbr_pkg::*;
(
   // clock
   input wire logic CORE_CLK,
   // transfer toward the recorder
   output xfer_type XFER
);
   initial XFER = '0;
   // one-cycle event; afterwards addresses invert so stale data never matches
   task automatic fire(input xfer_kind_type k, input logic [31:0] s, input logic [31:0] t);
      @(posedge CORE_CLK);
      XFER <= '{valid: 1'b1, kind: k, source: s, target: t};
      @(posedge CORE_CLK);
      XFER <= '{valid: 1'b0, kind: k, source: ~s, target: ~t};
   endtask
endmodule

// ==== testbench/last_branch_recorder_tb.sv ====
// bench: stack and pair recorders side by side on shared stimulus
// assumes the core model drives transfers, the bench drives register ops
`timescale 1ns/1ps
module last_branch_recorder_tb;
   import lbr_pkg::*;
   logic          clk = 1'b0, rst_n = 1'b0, priv_ok = 1'b1, step = 1'b0, full = 1'b0;
   logic          reg_wr = 1'b0, reg_rd = 1'b0;
   logic [11:0]   addr = 12'h000;
   logic [63:0]   wdata = 64'h0;
   logic [3:0]    bp = 4'h0, perf = 4'h0;
   xfer_type      xfer;
   logic [63:0]   rdata [2];
   logic          rvalid [2], wref [2], trx [2], tins [2], irq [2], wrap [2];
   logic [3:0]    pin [2];
   trace_msg_type tmsg [2];
   logic [31:0]   feat [2];
   int            n_fail = 0;
   int            checks_done = 0;
   always #2 clk = ~clk;
   core_model core_model_inst (.CORE_CLK(clk), .XFER(xfer));
   // index 0 holds the stack organisation, index 1 the pair
   for (genvar g = 0; g < 2; g++)
   begin : org
      last_branch_recorder #(.STACK_ORG(g == 0)) last_branch_recorder_inst (
         .CORE_CLK(clk), .RST_N(rst_n), .XFER(xfer), .PRIV_OK(priv_ok), .REG_WR(reg_wr),
         .REG_RD(reg_rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata[g]),
         .REG_RVALID(rvalid[g]), .REG_WREFUSED(wref[g]), .BP_MATCH(bp), .PERF_EVENT(perf),
         .BP_PIN_N(pin[g]), .SINGLE_STEP_FLAG(step), .STEP_TRAP_ON_XFER(trx[g]),
         .STEP_TRAP_ON_INSTR(tins[g]), .TRACE_MSG(tmsg[g]), .STORE_FULL(full),
         .STORE_FULL_IRQ(irq[g]), .STORE_WRAP(wrap[g]), .FEATURE_FLAGS(feat[g]));
   end
   task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] s);
      checks_done++;
      if (s !== e)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [63:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // m picks the recorders compared: bit 0 stack, bit 1 pair
   task automatic rd(input logic [11:0] a, input logic [1:0] m, input logic [63:0] es, input logic [63:0] ep);
      @(posedge clk);
      reg_rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      // answer stands for the cycle after the sampling edge only
      #1;
      if (m[0]) chk("stack read", {2'b01, es}, {1'b0, rvalid[0], rdata[0]});
      if (m[1]) chk("pair read", {2'b01, ep}, {1'b0, rvalid[1], rdata[1]});
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(REG_DBGCTL, 2'b11, 64'h0, 64'h0);
      rd(REG_TOS, 2'b01, 64'h0, 64'h0);
      rd(12'h123, 2'b11, 64'h0, 64'h0);
      chk("feature", 66'h3, {feat[0][FEAT_STORE_BIT], feat[1][FEAT_STORE_BIT]});
      wr(REG_DBGCTL, 64'hFFFF_FFFF_FFFF_FE01);
      rd(REG_DBGCTL, 2'b11, 64'h1, 64'h1);
      core_model_inst.fire(XFER_BRANCH, 32'h1000, 32'h2000);
      rd(REG_TOS, 2'b01, 64'h1, 64'h0);
      rd(REG_SLOT_FIRST + 12'h1, 2'b01, 64'h0000_2000_0000_1000, 64'h0);
      rd(REG_LB_TARGET, 2'b10, 64'h0, 64'h2000);
      core_model_inst.fire(XFER_EXCEPT, 32'h3000, 32'h4000);
      rd(REG_SLOT_FIRST + 12'h2, 2'b01, 64'h0000_4000_0000_3000, 64'h0);
      rd(REG_LE_SOURCE, 2'b10, 64'h0, 64'h1000);
      rd(REG_LB_SOURCE, 2'b10, 64'h0, 64'h3000);
      core_model_inst.fire(XFER_INTR, 32'h5000, 32'h6000);
      rd(REG_LE_TARGET, 2'b10, 64'h0, 64'h4000);
      rd(REG_LB_TARGET, 2'b10, 64'h0, 64'h6000);
      for (int i = 0; i < 5; i++)
         core_model_inst.fire(XFER_BRANCH, 32'h100 + 32'(i), 32'h200 + 32'(i));
      rd(REG_TOS, 2'b01, 64'h0, 64'h0);
      rd(REG_SLOT_FIRST, 2'b01, 64'h0000_0204_0000_0104, 64'h0);
      rd(REG_LE_SOURCE, 2'b10, 64'h0, 64'h3000);
      core_model_inst.fire(XFER_DEBUG, 32'h7777, 32'h8888);
      rd(REG_DBGCTL, 2'b11, 64'h1, 64'h0);
      rd(REG_TOS, 2'b01, 64'h0, 64'h0);
      rd(REG_LB_SOURCE, 2'b10, 64'h0, 64'h104);
      core_model_inst.fire(XFER_BRANCH, 32'h9000, 32'h9100);
      rd(REG_LB_SOURCE, 2'b10, 64'h0, 64'h104);
      rd(REG_SLOT_FIRST + 12'h1, 2'b01, 64'h0000_9100_0000_9000, 64'h0);
      wr(REG_DBGCTL, 64'h1);
      core_model_inst.fire(XFER_BRANCH, 32'hA000, 32'hA100);
      rd(REG_LB_SOURCE, 2'b10, 64'h0, 64'hA000);
      priv_ok <= 1'b0;
      wr(REG_DBGCTL, 64'h0C3);
      priv_ok <= 1'b1;
      #1;
      chk("write refused", 66'h1, {wref[0], wref[1]});
      rd(REG_DBGCTL, 2'b11, 64'h0C3, 64'h1);
      core_model_inst.fire(XFER_BRANCH, 32'hB000, 32'hB100);
      step <= 1'b1;
      #1;
      chk("trace msg", {2'b11, 32'hB000, 32'hB100}, tmsg[0]);
      repeat (2) @(posedge clk);
      #1;
      chk("step traps", 66'b1001, {trx[0], tins[0], trx[1], tins[1]});
      chk("store wrap", 66'h2, {wrap[0], wrap[1]});
      wr(REG_DBGCTL, 64'h181);
      full <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("full irq", 66'h3, {irq[0], irq[1]});
      wr(REG_DBGCTL, 64'h00D);
      full <= 1'b0;
      bp <= 4'hF;
      @(posedge clk);
      bp <= 4'h0;
      #1;
      chk("match pins", 66'hCC, {pin[0], pin[1]});
      @(posedge clk);
      perf <= 4'hF;
      @(posedge clk);
      perf <= 4'h0;
      #1;
      chk("perf pins", 66'h33, {pin[0], pin[1]});
      report_and_stop();
   end
   // watchdog, far beyond the roughly 105 cycles the run needs
   initial
   begin
      repeat (5000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
endmodule
